/* File: shared/temp_cal_pkg.sv */
`default_nettype none
package temp_cal_pkg;
  // Register indices on the plain register port
  localparam logic [3:0]  REG_CTRL       = 4'h0;
  localparam logic [3:0]  REG_OFFSET     = 4'h1;
  localparam logic [3:0]  REG_DELTA      = 4'h2;
  localparam logic [3:0]  REG_CYCLE      = 4'h3;
  localparam logic [3:0]  REG_STATUS     = 4'h4;
  localparam logic [3:0]  REG_TEMP       = 4'h5;
  // Control field positions
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_TEL_BIT   = 1;
  localparam int          CTRL_INV_BIT   = 2;
  localparam int          CTRL_W         = 3;
  // Status field positions
  localparam int          STAT_RUN_BIT   = 0;
  localparam int          STAT_SMP_BIT   = 1;
  localparam int          STAT_CAL_BIT   = 2;
  // Reset values
  localparam logic [2:0]  CTRL_RST       = 3'h0;
  localparam logic [8:0]  OFFSET_RST     = 9'h000;
  localparam logic [7:0]  DELTA_RST      = 8'h03;
  localparam logic [7:0]  CYCLE_RST      = 8'h0f;
  // Offset limit in 0.1 K steps, value scale is 0.01 K
  localparam int          OFFSET_MAX     = 200;
  localparam int          STEP_HUND      = 10;
  localparam logic [15:0] INVALID_WORD   = 16'h7fff;
  localparam logic [15:0] ZERO_WORD      = 16'h0000;
  // Timing
  localparam longint      CLK_HZ         = 100_000_000;
  localparam longint      MINUTE_S       = 60;
  localparam longint      MINUTE_CYCLES  = MINUTE_S * CLK_HZ;
  localparam int          VAL_W          = 18;
  localparam int          MANT_MAX       = 2047;
  localparam int          EXP_STEPS      = 7;
endpackage
`default_nettype wire

/* File: shared/temp_codec_if.sv */
`default_nettype none
interface temp_codec_if;
  logic signed [17:0] enc_val;
  logic        [15:0] enc_word;
  logic        [15:0] dec_word;
  logic signed [17:0] dec_val;
  modport main  (output enc_val, output dec_word, input enc_word, input dec_val);
  modport codec (input enc_val, input dec_word, output enc_word, output dec_val);
endinterface
`default_nettype wire

/* File: design/temp_float_codec.sv */
`default_nettype none
module temp_float_codec (
  temp_codec_if.codec c                          // Encode and decode pair
);
  // Two-byte float: sign, 4-bit exponent, 11-bit mantissa, value 0.01 K * M * 2^E
  function automatic logic [15:0] encode(input logic signed [17:0] v);
    logic signed [17:0] m;
    logic        [3:0]  e;
    m = v;
    e = 4'h0;
    for (int i = 0; i < temp_cal_pkg::EXP_STEPS; i++) begin
      if (m > 18'sd2047 || m < -18'sd2048) begin
        m = m >>> 1;
        e = e + 4'h1;
      end
    end
    return {m[11], e, m[10:0]};
  endfunction

  // Wide exponents are clamped to the internal value range
  function automatic logic signed [17:0] decode(input logic [15:0] w);
    logic signed [11:0] m;
    logic signed [31:0] t;
    m = $signed({w[15], w[10:0]});
    t = 32'(m) <<< w[14:11];
    if (t > 32'sd131071) begin
      return 18'sd131071;
    end else if (t < -32'sd131072) begin
      return -18'sd131072;
    end
    return 18'(t);
  endfunction

  always_comb begin
    c.enc_word = encode(c.enc_val);
    c.dec_val  = decode(c.dec_word);
  end
endmodule
`default_nettype wire

/* File: design/room_temperature_calibration.sv */
`default_nettype none
module room_temperature_calibration #(
  parameter longint             MINUTE_CYCLES = temp_cal_pkg::MINUTE_CYCLES,
  parameter logic signed [17:0] FACTORY_REF   = 18'sh00000
) (
  input  wire logic        clk_i,           // 100 MHz clock
  input  wire logic        rstn_i,          // Async reset, active low
  input  wire logic [3:0]  addr_i,          // Register index
  input  wire logic [15:0] wdata_i,         // Register write data
  input  wire logic        wr_i,            // Write strobe
  input  wire logic        rd_i,            // Read strobe
  output logic      [15:0] rdata_o,         // Read data, cycle after rd_i
  input  wire logic [15:0] sample_i,        // Raw sensor value, 0.01 K signed
  input  wire logic        sample_valid_i,  // Sample strobe
  input  wire logic [15:0] cal_word_i,      // Calibration object value
  input  wire logic        cal_valid_i,     // Calibration object received
  input  wire logic        nvm_ready_i,     // Stored data readable
  input  wire logic        nvm_cal_i,       // Stored reference is valid
  input  wire logic [17:0] nvm_ref_i,       // Stored reference
  output logic             nvm_wr_o,        // Store reference pulse
  output logic      [17:0] nvm_wdata_o,     // Reference to store
  output logic      [15:0] temp_word_o,     // Temperature output object
  output logic             temp_send_o      // Transmit pulse
);
  localparam int MW = $clog2(MINUTE_CYCLES + 1);

  if (MINUTE_CYCLES < 2) begin : g_bad_minute
    $error("MINUTE_CYCLES must be at least 2");
  end

  typedef enum logic [0:0] {ST_LOAD, ST_RUN} state_t;

  temp_codec_if cdc ();
  temp_float_codec u_codec (
    .c (cdc.codec)
  );

  // Register file
  logic        [2:0]  ctrl_ff,   nxt_ctrl;
  logic signed [8:0]  offset_ff, nxt_offset;
  logic        [7:0]  delta_ff,  nxt_delta;
  logic        [7:0]  cycle_ff,  nxt_cycle;
  logic        [15:0] rdata_ff,  nxt_rdata;
  // Calibration state
  state_t             state_ff,  nxt_state;
  logic signed [17:0] ref_ff,    nxt_ref;
  logic               cal_ff,    nxt_cal;
  logic               nvw_ff,    nxt_nvw;
  logic        [17:0] nvd_ff,    nxt_nvd;
  // Measurement
  logic signed [15:0] raw_ff,    nxt_raw;
  logic               smp_ff,    nxt_smp;
  logic signed [17:0] temp_ff,   nxt_temp;
  // Transmission
  logic signed [17:0] last_ff,   nxt_last;
  logic        [MW-1:0] tick_ff, nxt_tick;
  logic        [7:0]  min_ff,    nxt_min;
  logic        [15:0] word_ff,   nxt_word;
  logic               send_ff,   nxt_send;

  logic               en;
  logic               tel;
  logic signed [17:0] raw_ext;
  logic signed [17:0] off_h;
  logic               cal_take;
  logic        [15:0] out_word;
  logic               out_valid;
  logic signed [18:0] diff;
  logic        [18:0] adiff;
  logic               chg_hit;
  logic               min_tick;
  logic               cyc_hit;
  logic               send_now;
  logic signed [15:0] wsig;

  assign en      = ctrl_ff[temp_cal_pkg::CTRL_EN_BIT];
  assign tel     = ctrl_ff[temp_cal_pkg::CTRL_TEL_BIT];
  assign raw_ext = 18'(raw_ff);
  assign off_h   = 18'(18'(offset_ff) * 18'(temp_cal_pkg::STEP_HUND));
  assign wsig    = $signed(wdata_i);

  // Register port
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_offset = offset_ff;
    nxt_delta  = delta_ff;
    nxt_cycle  = cycle_ff;
    nxt_rdata  = 16'h0000;
    if (wr_i) begin
      unique case (addr_i)
        temp_cal_pkg::REG_CTRL: begin
          nxt_ctrl = wdata_i[temp_cal_pkg::CTRL_W-1:0];
        end
        temp_cal_pkg::REG_OFFSET: begin
          // Out-of-range offsets saturate rather than wrap
          if (wsig > 16'(temp_cal_pkg::OFFSET_MAX)) begin
            nxt_offset = 9'(temp_cal_pkg::OFFSET_MAX);
          end else if (wsig < -16'(temp_cal_pkg::OFFSET_MAX)) begin
            nxt_offset = -9'(temp_cal_pkg::OFFSET_MAX);
          end else begin
            nxt_offset = 9'(wsig);
          end
        end
        temp_cal_pkg::REG_DELTA: begin
          nxt_delta = wdata_i[7:0];
        end
        temp_cal_pkg::REG_CYCLE: begin
          nxt_cycle = wdata_i[7:0];
        end
        default: begin
        end
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        temp_cal_pkg::REG_CTRL:   nxt_rdata = {13'h0000, ctrl_ff};
        temp_cal_pkg::REG_OFFSET: nxt_rdata = {7'h00, offset_ff};
        temp_cal_pkg::REG_DELTA:  nxt_rdata = {8'h00, delta_ff};
        temp_cal_pkg::REG_CYCLE:  nxt_rdata = {8'h00, cycle_ff};
        temp_cal_pkg::REG_STATUS: nxt_rdata = {13'h0000, cal_ff, smp_ff, state_ff == ST_RUN};
        temp_cal_pkg::REG_TEMP:   nxt_rdata = out_word;
        default:                  nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_ff   <= temp_cal_pkg::CTRL_RST;
      offset_ff <= temp_cal_pkg::OFFSET_RST;
      delta_ff  <= temp_cal_pkg::DELTA_RST;
      cycle_ff  <= temp_cal_pkg::CYCLE_RST;
      rdata_ff  <= 16'h0000;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      offset_ff <= nxt_offset;
      delta_ff  <= nxt_delta;
      cycle_ff  <= nxt_cycle;
      rdata_ff  <= nxt_rdata;
    end
  end
  assign rdata_o = rdata_ff;

  // Calibration: stored reference is loaded once storage is readable after reset
  assign cdc.dec_word = cal_word_i;
  assign cal_take = cal_valid_i && tel && smp_ff && (state_ff == ST_RUN);

  always_comb begin
    nxt_state = state_ff;
    nxt_ref   = ref_ff;
    nxt_cal   = cal_ff;
    nxt_nvw   = 1'b0;
    nxt_nvd   = nvd_ff;
    unique case (state_ff)
      ST_LOAD: begin
        if (nvm_ready_i) begin
          nxt_state = ST_RUN;
          nxt_ref   = $signed(nvm_ref_i);
          nxt_cal   = nvm_cal_i;
        end
      end
      ST_RUN: begin
        if (cal_take) begin
          nxt_ref = 18'(cdc.dec_val - raw_ext);
          nxt_cal = 1'b1;
          nxt_nvw = 1'b1;
          nxt_nvd = 18'(cdc.dec_val - raw_ext);
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= ST_LOAD;
      ref_ff   <= 18'sh00000;
      cal_ff   <= 1'b0;
      nvw_ff   <= 1'b0;
      nvd_ff   <= 18'h00000;
    end else begin
      state_ff <= nxt_state;
      ref_ff   <= nxt_ref;
      cal_ff   <= nxt_cal;
      nvw_ff   <= nxt_nvw;
      nvd_ff   <= nxt_nvd;
    end
  end
  assign nvm_wr_o    = nvw_ff;
  assign nvm_wdata_o = nvd_ff;

  // Measurement and correction
  always_comb begin
    nxt_raw = raw_ff;
    nxt_smp = smp_ff;
    if (sample_valid_i && en) begin
      nxt_raw = $signed(sample_i);
      nxt_smp = 1'b1;
    end
    if (tel) begin
      nxt_temp = 18'(raw_ext + ref_ff);
    end else begin
      nxt_temp = 18'(raw_ext + FACTORY_REF + off_h);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      raw_ff  <= 16'sh0000;
      smp_ff  <= 1'b0;
      temp_ff <= 18'sh00000;
    end else begin
      raw_ff  <= nxt_raw;
      smp_ff  <= nxt_smp;
      temp_ff <= nxt_temp;
    end
  end

  // Output word; uncalibrated telegram mode never exposes a measurement
  assign cdc.enc_val = temp_ff;
  assign out_valid   = !tel || cal_ff;
  always_comb begin
    if (out_valid) begin
      out_word = cdc.enc_word;
    end else if (ctrl_ff[temp_cal_pkg::CTRL_INV_BIT]) begin
      out_word = temp_cal_pkg::INVALID_WORD;
    end else begin
      out_word = temp_cal_pkg::ZERO_WORD;
    end
  end

  // Triggers
  assign diff     = 19'(temp_ff) - 19'(last_ff);
  assign adiff    = diff[18] ? 19'(-diff) : 19'(diff);
  assign chg_hit  = (delta_ff != 8'h00) && out_valid &&
                    (adiff >= 19'(delta_ff) * 19'(temp_cal_pkg::STEP_HUND));
  assign min_tick = (tick_ff == MW'(MINUTE_CYCLES - 1));
  assign cyc_hit  = min_tick && (cycle_ff != 8'h00) &&
                    (min_ff >= cycle_ff - 8'h01);
  assign send_now = en && smp_ff && (state_ff == ST_RUN) && (chg_hit || cyc_hit);

  always_comb begin
    nxt_tick = min_tick ? '0 : MW'(tick_ff + 1'b1);
    nxt_min  = min_ff;
    if (cycle_ff == 8'h00) begin
      nxt_min = 8'h00;
    end else if (cyc_hit) begin
      nxt_min = 8'h00;
    end else if (min_tick) begin
      nxt_min = 8'(min_ff + 8'h01);
    end
    nxt_last = last_ff;
    nxt_word = word_ff;
    nxt_send = send_now;
    if (send_now) begin
      nxt_last = temp_ff;
      nxt_word = out_word;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_ff <= '0;
      min_ff  <= 8'h00;
      last_ff <= 18'sh00000;
      word_ff <= 16'h0000;
      send_ff <= 1'b0;
    end else begin
      tick_ff <= nxt_tick;
      min_ff  <= nxt_min;
      last_ff <= nxt_last;
      word_ff <= nxt_word;
      send_ff <= nxt_send;
    end
  end
  assign temp_word_o = word_ff;
  assign temp_send_o = send_ff;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  disabled_silent_a: assert property (
    !en |=> !temp_send_o)
    else $error("transmission while function disabled");

  factory_ref_a: assert property (
    (rstn_i && !tel && offset_ff == 9'sd0) |=> temp_ff == 18'($past(raw_ext) + FACTORY_REF))
    else $error("factory reading not sensor plus reference");

  offset_range_a: assert property (
    offset_ff <= 9'sd200 && offset_ff >= -9'sd200)
    else $error("offset outside range");

  cal_accept_a: assert property (
    cal_take |=> cal_ff && nvm_wr_o)
    else $error("calibration value not taken");

  cal_equate_a: assert property (
    (cal_take && !sample_valid_i) ##1 tel |=> temp_ff == $past(cdc.dec_val, 2))
    else $error("reading not equal to calibration value");

  tel_ignores_a: assert property (
    tel |=> temp_ff == 18'($past(raw_ext) + $past(ref_ff)))
    else $error("factory reference used in telegram mode");

  nvm_store_a: assert property (
    nvm_wr_o |-> nvm_wdata_o == ref_ff && $past(cal_take))
    else $error("stored reference differs from active one");

  invalid_word_a: assert property (
    (temp_send_o && $past(tel && !cal_ff)) |->
      temp_word_o == ($past(ctrl_ff[temp_cal_pkg::CTRL_INV_BIT]) ? 16'h7fff : 16'h0000))
    else $error("uncalibrated output not zero or invalid marker");

  no_trigger_a: assert property (
    (delta_ff == 8'h00 && cycle_ff == 8'h00) [*2] |-> !temp_send_o)
    else $error("transmission with both triggers off");

  cycle_send_a: assert property (
    (cyc_hit && en && smp_ff && state_ff == ST_RUN) |=> temp_send_o)
    else $error("periodic transmission missed");

  encode_a: assert property (
    (temp_send_o && $past(out_valid)) |-> temp_word_o == $past(cdc.enc_word))
    else $error("output word not float-coded reading");

  cal_seen_c:  cover property (cal_take ##1 nvm_wr_o);
  chg_send_c:  cover property (chg_hit && send_now ##1 temp_send_o);
  cyc_send_c:  cover property (cyc_hit && send_now ##1 temp_send_o);
  inv_send_c:  cover property (temp_send_o && temp_word_o == 16'h7fff);
endmodule
`default_nettype wire

/* File: testbench/nvm_store_model.sv */
`default_nettype none
module nvm_store_model (
  input  wire logic        clk_i,    // System clock
  input  wire logic        rstn_i,   // Device reset
  input  wire logic        wr_i,     // Store strobe
  input  wire logic [17:0] wdata_i,  // Reference to keep
  output logic             ready_o,  // Contents readable
  output logic             cal_o,    // Kept reference valid
  output logic      [17:0] ref_o     // Kept reference
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] mem_ff = 18'h00000;
  logic        val_ff = 1'b0;
  logic [1:0]  wait_ff;
  // Contents ignore reset on purpose, only the read path restarts
  always @(posedge clk_i) begin
    if (wr_i === 1'b1) begin
      mem_ff <= wdata_i;
      val_ff <= 1'b1;
    end
  end
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_ff <= 2'h0;
    end else if (wait_ff != 2'h3) begin
      wait_ff <= wait_ff + 2'h1;
    end
  end
  assign ready_o = (wait_ff == 2'h3);
  assign cal_o   = ready_o ? val_ff : 1'b0;
  // Lines carry junk until readable, so a stale value is never trusted
  assign ref_o   = ready_o ? mem_ff : ~mem_ff;
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i          = 1'b0;
  logic        rstn_i         = 1'b0;
  logic [3:0]  addr_i         = 4'h0;
  logic [15:0] wdata_i        = 16'h0000;
  logic        wr_i           = 1'b0;
  logic        rd_i           = 1'b0;
  logic [15:0] sample_i       = 16'h0000;
  logic        sample_valid_i = 1'b0;
  logic [15:0] cal_word_i     = 16'h0000;
  logic        cal_valid_i    = 1'b0;
  logic [15:0] rdata_o;
  logic [15:0] temp_word_o;
  logic        nvm_ready_i;
  logic        nvm_cal_i;
  logic        nvm_wr_o;
  logic        temp_send_o;
  logic [17:0] nvm_ref_i;
  logic [17:0] nvm_wdata_o;
  int          n_fail         = 0;
  int          tests_run      = 0;
  int          n_send         = 0;
  int          gap;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (temp_send_o === 1'b1) n_send++;

  room_temperature_calibration #(.MINUTE_CYCLES(20), .FACTORY_REF(18'sd500)) u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .sample_i(sample_i), .sample_valid_i(sample_valid_i),
    .cal_word_i(cal_word_i), .cal_valid_i(cal_valid_i), .nvm_ready_i(nvm_ready_i),
    .nvm_cal_i(nvm_cal_i), .nvm_ref_i(nvm_ref_i), .nvm_wr_o(nvm_wr_o),
    .nvm_wdata_o(nvm_wdata_o), .temp_word_o(temp_word_o), .temp_send_o(temp_send_o));

  nvm_store_model u_nvm (.clk_i(clk_i), .rstn_i(rstn_i), .wr_i(nvm_wr_o),
    .wdata_i(nvm_wdata_o), .ready_o(nvm_ready_i), .cal_o(nvm_cal_i), .ref_o(nvm_ref_i));

  function automatic logic [15:0] enc(input int v);
    int e;
    logic [11:0] m;
    e = 0;
    while (v > 2047 || v < -2048) begin
      v = v >>> 1;
      e++;
    end
    m = v[11:0];
    return {m[11], e[3:0], m[10:0]};
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    `CHK(rdata_o, e)
  endtask

  task automatic smp(input logic [15:0] v);
    @(posedge clk_i);
    sample_i       <= v;
    sample_valid_i <= 1'b1;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
  endtask

  // Waits for the next transmit pulse and reports how many cycles it took
  task automatic sendc(input logic [15:0] e, output int n);
    int i;
    for (i = 0; i < 200; i++) begin
      @(negedge clk_i);
      if (temp_send_o === 1'b1) break;
    end
    n = i + 1;
    if (i == 200) begin
      n_fail++;
      wrap_up();
    end else begin
      `CHK(temp_word_o, e)
    end
  endtask

  task automatic quiet(input int n);
    int k;
    k = n_send;
    idle(n);
    `CHK(n_send, k)
  endtask

  task automatic t_reset();
    rdc(temp_cal_pkg::REG_CTRL, 16'h0000);
    rdc(temp_cal_pkg::REG_OFFSET, 16'h0000);
    rdc(temp_cal_pkg::REG_DELTA, 16'h0003);
    rdc(temp_cal_pkg::REG_CYCLE, 16'h000f);
    rdc(4'hf, 16'h0000);
    rdc(temp_cal_pkg::REG_STATUS, 16'h0001);
  endtask

  task automatic t_disabled();
    wr(temp_cal_pkg::REG_CYCLE, 16'h0001);
    smp(16'd2000);
    quiet(60);
    rdc(temp_cal_pkg::REG_STATUS, 16'h0001);
  endtask

  task automatic t_factory();
    wr(temp_cal_pkg::REG_OFFSET, 16'd250);
    rdc(temp_cal_pkg::REG_OFFSET, 16'h00c8);
    wr(temp_cal_pkg::REG_OFFSET, 16'hfed4);
    rdc(temp_cal_pkg::REG_OFFSET, 16'h0138);
    wr(temp_cal_pkg::REG_OFFSET, 16'h00c8);
    wr(temp_cal_pkg::REG_CTRL, 16'h0001);
    smp(16'd2000);
    idle(4);
    sendc(enc(4500), gap);
    wr(temp_cal_pkg::REG_OFFSET, 16'hfffb);
    smp(16'hf448);
    idle(4);
    sendc(enc(-2550), gap);
  endtask

  task automatic t_change();
    wr(temp_cal_pkg::REG_CYCLE, 16'h0000);
    wr(temp_cal_pkg::REG_DELTA, 16'h0001);
    idle(10);
    smp(16'hf44d);
    quiet(20);
    smp(16'hf452);
    sendc(enc(-2540), gap);
    wr(temp_cal_pkg::REG_DELTA, 16'h0000);
    smp(16'h0000);
    quiet(30);
  endtask

  task automatic t_uncal();
    wr(temp_cal_pkg::REG_CTRL, 16'h0007);
    wr(temp_cal_pkg::REG_CYCLE, 16'h0001);
    idle(4);
    sendc(16'h7fff, gap);
    rdc(temp_cal_pkg::REG_TEMP, 16'h7fff);
    wr(temp_cal_pkg::REG_CTRL, 16'h0003);
    wr(temp_cal_pkg::REG_CYCLE, 16'h0002);
    idle(4);
    sendc(16'h0000, gap);
    sendc(16'h0000, gap);
    `CHK(gap, 40)
  endtask

  task automatic t_cal();
    wr(temp_cal_pkg::REG_CYCLE, 16'h0000);
    wr(temp_cal_pkg::REG_DELTA, 16'h0001);
    smp(16'd1000);
    idle(2);
    @(posedge clk_i);
    cal_word_i  <= enc(2150);
    cal_valid_i <= 1'b1;
    @(posedge clk_i);
    cal_valid_i <= 1'b0;
    @(negedge clk_i);
    `CHK(nvm_wr_o, 1'b1)
    `CHK(nvm_wdata_o, 18'd1150)
    rdc(temp_cal_pkg::REG_STATUS, 16'h0007);
    idle(6);
    // Factory reference of 500 must not show up here
    smp(16'd1200);
    sendc(enc(2350), gap);
    rdc(temp_cal_pkg::REG_TEMP, enc(2350));
  endtask

  task automatic t_retain();
    @(posedge clk_i);
    rstn_i <= 1'b0;
    idle(2);
    rstn_i <= 1'b1;
    idle(8);
    wr(temp_cal_pkg::REG_CTRL, 16'h0003);
    wr(temp_cal_pkg::REG_CYCLE, 16'h0001);
    smp(16'd1200);
    idle(4);
    sendc(enc(2350), gap);
  endtask

  initial begin
    idle(2);
    rstn_i <= 1'b1;
    idle(6);
    t_reset();
    t_disabled();
    t_factory();
    t_change();
    t_uncal();
    t_cal();
    t_retain();
    wrap_up();
  end
endmodule
`default_nettype wire
